/* File: include/gtc_pkg.sv */
// Package of constants and a helper function for the general timer control block.
package gtc_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [3:0]  GTC_ADDR_CONTROL  = 4'h0;
	localparam logic [3:0]  GTC_ADDR_COUNT_LO = 4'h1;
	localparam logic [3:0]  GTC_ADDR_COUNT_HI = 4'h2;
	localparam logic [3:0]  GTC_ADDR_STATUS   = 4'h3;

	// -----------------------------------------------------------------
	// Control field positions
	// -----------------------------------------------------------------
	localparam int GTC_BIT_RUN        = 15;
	localparam int GTC_BIT_HALT_IDLE  = 13;
	localparam int GTC_BIT_GATED      = 6;
	localparam int GTC_BIT_PRESCALE_L = 4;
	localparam int GTC_BIT_PAIRED     = 3;
	localparam int GTC_BIT_CLK_SRC    = 1;

	// Writable bits of the control register; all other bits read as zero.
	localparam logic [15:0] GTC_CONTROL_MASK  = 16'hA07A;
	localparam logic [15:0] GTC_CONTROL_RESET = 16'h0000;

	// -----------------------------------------------------------------
	// Prescale dividers, one less than the ratio
	// -----------------------------------------------------------------
	localparam logic [7:0]  GTC_DIV_1   = 8'h00;
	localparam logic [7:0]  GTC_DIV_8   = 8'h07;
	localparam logic [7:0]  GTC_DIV_64  = 8'h3F;
	localparam logic [7:0]  GTC_DIV_256 = 8'hFF;

	// Terminal count of the prescaler for a 2-bit select code.
	function automatic logic [7:0] gtc_div_limit(input logic [1:0] code);
		case (code)
			2'h0:    gtc_div_limit = GTC_DIV_1;
			2'h1:    gtc_div_limit = GTC_DIV_8;
			2'h2:    gtc_div_limit = GTC_DIV_64;
			default: gtc_div_limit = GTC_DIV_256;
		endcase
	endfunction : gtc_div_limit

endpackage : gtc_pkg

/* File: core/gtc_prescaler.sv */
// Input prescaler that turns count ticks into divided counter advances.
`timescale 1ns/1ps
module gtc_prescaler
	import gtc_pkg::*;
(
	input  wire logic       clk,      // Peripheral clock.
	input  wire logic       rst,      // Synchronous reset, active high.
	input  wire logic       clear,    // Restarts the division.
	input  wire logic       tick,     // One-cycle input tick.
	input  wire logic [1:0] select,   // Prescale select code.
	output logic            advance   // One-cycle pulse per divided tick.
);

	logic [7:0] count;
	logic [7:0] next_count;
	logic       next_advance;

	always_comb begin
		next_count   = count;
		next_advance = 1'b0;
		if (clear) begin
			next_count = 8'h00;
		end else if (tick) begin
			if (count >= gtc_div_limit(select)) begin
				next_count   = 8'h00;
				next_advance = 1'b1;
			end else begin
				next_count = count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count   <= 8'h00;
			advance <= 1'b0;
		end else begin
			count   <= next_count;
			advance <= next_advance;
		end
	end

endmodule : gtc_prescaler

/* File: core/gtc_timer.sv */
// General timer with run control, gating, prescaler, clock select and 32-bit pairing.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Run bit starts or stops the 16-bit timer, or the paired 32-bit timer.
// - Gated accumulation has no effect while the external pin clock is selected.
// - Prescale codes 00,01,10,11 divide the input clock by 1, 8, 64, 256.
// - Clock select set counts external pin rising edges; clear counts internal clock.
module gtc_timer
	import gtc_pkg::*;
#(
	parameter int HALF_WIDTH = 16  // Width of one counter half and of the register bus.
)
(
	input  wire logic        clk,                 // Peripheral clock, 100 MHz.
	input  wire logic        rst,                 // Synchronous reset, active high.
	input  wire logic [3:0]  addr,                // Register address.
	input  wire logic [15:0] wdata,               // Write data.
	input  wire logic        wr,                  // Write strobe.
	input  wire logic        rd,                  // Read strobe.
	output logic      [15:0] rdata,               // Read data, valid the cycle after rd.
	input  wire logic        external_count_pin,  // External count clock pin.
	input  wire logic        gate_in,             // Gate input for gated accumulation.
	input  wire logic        idle_mode,           // Device is in idle mode.
	output logic             counting,            // Counter advances are enabled.
	output logic      [31:0] count_value          // Current counter value.
);

	// -----------------------------------------------------------------
	// Elaboration checks
	// -----------------------------------------------------------------
	// The bus, the control word and each counter half share one width.
	if (HALF_WIDTH != 16) begin : g_bad_half_width
		$error("gtc_timer serves only a half width of 16 bits");
	end

	// Every control field must sit inside the writable part of the control word.
	if (!GTC_CONTROL_MASK[GTC_BIT_RUN] || !GTC_CONTROL_MASK[GTC_BIT_HALT_IDLE]
		|| !GTC_CONTROL_MASK[GTC_BIT_GATED] || !GTC_CONTROL_MASK[GTC_BIT_PAIRED]
		|| !GTC_CONTROL_MASK[GTC_BIT_PRESCALE_L] || !GTC_CONTROL_MASK[GTC_BIT_PRESCALE_L + 1]
		|| !GTC_CONTROL_MASK[GTC_BIT_CLK_SRC]) begin : g_bad_field
		$error("gtc_timer control field lies outside the writable mask");
	end

	// The prescale field is two bits wide and must not run off the word.
	if (GTC_BIT_PRESCALE_L + 2 > HALF_WIDTH) begin : g_bad_prescale
		$error("gtc_timer prescale field runs off the control word");
	end

	// A reset value with unimplemented bits set would read back as nonzero.
	if ((GTC_CONTROL_RESET & ~GTC_CONTROL_MASK) != 16'h0000) begin : g_bad_reset
		$error("gtc_timer control reset value sets unimplemented bits");
	end

	// Each writable register needs an address of its own.
	if (GTC_ADDR_CONTROL == GTC_ADDR_COUNT_LO || GTC_ADDR_CONTROL == GTC_ADDR_COUNT_HI
		|| GTC_ADDR_COUNT_LO == GTC_ADDR_COUNT_HI) begin : g_bad_map
		$error("gtc_timer register addresses overlap");
	end

	// Prescale dividers must grow with the select code.
	if (GTC_DIV_1 >= GTC_DIV_8 || GTC_DIV_8 >= GTC_DIV_64 || GTC_DIV_64 >= GTC_DIV_256) begin : g_bad_div
		$error("gtc_timer prescale dividers are out of order");
	end

	// -----------------------------------------------------------------
	// Helper functions
	// -----------------------------------------------------------------
	// True when a strobe is raised for the given register address.
	function automatic logic reg_hit(
		input logic       strobe,
		input logic [3:0] where,
		input logic [3:0] target
	);
		reg_hit = strobe && (where == target);
	endfunction : reg_hit

	// Adds one to a counter half and returns the carry out above it.
	function automatic logic [HALF_WIDTH:0] half_step(input logic [HALF_WIDTH-1:0] value);
		half_step = {1'b0, value} + {{HALF_WIDTH{1'b0}}, 1'b1};
	endfunction : half_step

	// -----------------------------------------------------------------
	// Control register
	// -----------------------------------------------------------------
	logic [15:0] timer_control;
	logic [15:0] next_timer_control;

	logic        run_control;
	logic        halt_in_idle;
	logic        gated_accumulate_enable;
	logic [1:0]  input_prescale_select;
	logic        paired_wide_mode;
	logic        clock_source_select;

	assign run_control             = timer_control[GTC_BIT_RUN];
	assign halt_in_idle            = timer_control[GTC_BIT_HALT_IDLE];
	assign gated_accumulate_enable = timer_control[GTC_BIT_GATED];
	assign input_prescale_select   = timer_control[GTC_BIT_PRESCALE_L +: 2];
	assign paired_wide_mode        = timer_control[GTC_BIT_PAIRED];
	assign clock_source_select     = timer_control[GTC_BIT_CLK_SRC];

	always_comb begin
		next_timer_control = timer_control;
		if (reg_hit(wr, addr, GTC_ADDR_CONTROL)) begin
			next_timer_control = wdata & GTC_CONTROL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			timer_control <= GTC_CONTROL_RESET;
		end else begin
			timer_control <= next_timer_control;
		end
	end

	// -----------------------------------------------------------------
	// External pin edge detection
	// -----------------------------------------------------------------
	// Edges that arrive while counting is held off are dropped, not saved for later.
	logic pin_last;
	logic next_pin_last;
	logic pin_rise;

	always_comb begin
		next_pin_last = external_count_pin;
		pin_rise      = external_count_pin && !pin_last;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_last <= 1'b0;
		end else begin
			pin_last <= next_pin_last;
		end
	end

	// -----------------------------------------------------------------
	// Tick source selection
	// -----------------------------------------------------------------
	logic tick;
	logic enable;
	logic advance;
	logic prescale_clear;

	always_comb begin
		// Idle halt and the run bit gate all counting.
		enable = run_control && !(halt_in_idle && idle_mode);
		if (clock_source_select) begin
			tick = pin_rise;
		end else if (gated_accumulate_enable) begin
			tick = gate_in;
		end else begin
			tick = 1'b1;
		end
		tick = tick && enable;
		// The prescaler restarts each time the run bit goes low.
		prescale_clear = !run_control;
	end

	gtc_prescaler u_prescaler (
		.clk     (clk),
		.rst     (rst),
		.clear   (prescale_clear),
		.tick    (tick),
		.select  (input_prescale_select),
		.advance (advance)
	);

	// -----------------------------------------------------------------
	// Run state
	// -----------------------------------------------------------------
	// Stopped: run bit clear. Active: advancing. Halted: run bit set but held in idle.
	typedef enum logic [2:0] {
		GTC_RUN_STOPPED = 3'b001,
		GTC_RUN_ACTIVE  = 3'b010,
		GTC_RUN_HALTED  = 3'b100
	} gtc_run_state_t;

	gtc_run_state_t run_state;
	gtc_run_state_t next_run_state;
	logic           next_counting;

	always_comb begin
		next_run_state = run_state;
		case (run_state)
			GTC_RUN_STOPPED: begin
				if (enable) begin
					next_run_state = GTC_RUN_ACTIVE;
				end else if (run_control) begin
					next_run_state = GTC_RUN_HALTED;
				end
			end
			GTC_RUN_ACTIVE: begin
				if (!run_control) begin
					next_run_state = GTC_RUN_STOPPED;
				end else if (!enable) begin
					next_run_state = GTC_RUN_HALTED;
				end
			end
			GTC_RUN_HALTED: begin
				if (!run_control) begin
					next_run_state = GTC_RUN_STOPPED;
				end else if (enable) begin
					next_run_state = GTC_RUN_ACTIVE;
				end
			end
			default: begin
				next_run_state = GTC_RUN_STOPPED;
			end
		endcase
		// The status output shows the state entered at this edge, one cycle after enable.
		next_counting = (next_run_state == GTC_RUN_ACTIVE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run_state <= GTC_RUN_STOPPED;
			counting  <= 1'b0;
		end else begin
			run_state <= next_run_state;
			counting  <= next_counting;
		end
	end

	// -----------------------------------------------------------------
	// Counter
	// -----------------------------------------------------------------
	logic [HALF_WIDTH-1:0] count_lo;
	logic [HALF_WIDTH-1:0] count_hi;
	logic [HALF_WIDTH-1:0] next_count_lo;
	logic [HALF_WIDTH-1:0] next_count_hi;
	logic [HALF_WIDTH:0]   step_lo;
	logic [HALF_WIDTH:0]   step_hi;
	logic                  count_step;
	logic                  count_write;

	// Low half: a software write to either half wins over an advance in that cycle.
	always_comb begin
		step_lo       = half_step(count_lo);
		count_step    = advance && enable;
		count_write   = reg_hit(wr, addr, GTC_ADDR_COUNT_LO) || reg_hit(wr, addr, GTC_ADDR_COUNT_HI);
		next_count_lo = count_lo;
		if (reg_hit(wr, addr, GTC_ADDR_COUNT_LO)) begin
			next_count_lo = wdata;
		end else if (count_step && !count_write) begin
			next_count_lo = step_lo[HALF_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_lo <= {HALF_WIDTH{1'b0}};
		end else begin
			count_lo <= next_count_lo;
		end
	end

	// High half: follows the carry of the low half only while the halves are paired.
	always_comb begin
		step_hi       = half_step(count_hi);
		next_count_hi = count_hi;
		if (reg_hit(wr, addr, GTC_ADDR_COUNT_HI)) begin
			next_count_hi = wdata;
		end else if (!count_write && count_step && paired_wide_mode && step_lo[HALF_WIDTH]) begin
			next_count_hi = step_hi[HALF_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_hi <= {HALF_WIDTH{1'b0}};
		end else begin
			count_hi <= next_count_hi;
		end
	end

	// Both halves are registers, so the counter output comes straight from flip-flops.
	assign count_value = {count_hi, count_lo};

	// -----------------------------------------------------------------
	// Read port
	// -----------------------------------------------------------------
	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		// Cycles without a read answer return zero on the read data.
		if (rd) begin
			case (addr)
				GTC_ADDR_CONTROL:  next_rdata = timer_control;
				GTC_ADDR_COUNT_LO: next_rdata = count_value[15:0];
				GTC_ADDR_COUNT_HI: next_rdata = count_value[31:16];
				GTC_ADDR_STATUS:   next_rdata = {15'h0000, counting};
				default:           next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= next_rdata;
		end
	end

endmodule : gtc_timer

/* File: tb/gtc_timer_properties.sv */
// Concurrent checks on the ports of the general timer.
`timescale 1ns/1ps
module gtc_timer_properties
	import gtc_pkg::*;
(
	input wire logic        clk,          // Peripheral clock.
	input wire logic        rst,          // Synchronous reset.
	input wire logic [3:0]  addr,         // Register address.
	input wire logic        wr,           // Write strobe.
	input wire logic        rd,           // Read strobe.
	input wire logic [15:0] rdata,        // Read data.
	input wire logic        counting,     // Counting enabled.
	input wire logic [31:0] count_value   // Counter value.
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [2:0] stop_cnt;
	logic [2:0] next_stop_cnt;
	// Counts the cycles since counting went off, so the advance pipeline has drained.
	always_comb begin
		next_stop_cnt = (counting || stop_cnt == 3'h7) ? (counting ? 3'h0 : stop_cnt) : stop_cnt + 3'h1;
	end
	always_ff @(posedge clk) begin
		stop_cnt <= rst ? 3'h0 : next_stop_cnt;
	end
	a_read_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data seen outside a read answer cycle");
	a_ctrl_unused_zero: assert property ($past(rd) && $past(addr) == GTC_ADDR_CONTROL |->
		(rdata & ~GTC_CONTROL_MASK) == 16'h0000) else $error("unused control bits read as one");
	a_status_run: assert property ($past(rd) && $past(addr) == GTC_ADDR_STATUS |->
		rdata == {15'h0000, $past(counting)}) else $error("status does not show counting state");
	a_count_step_one: assert property (!$past(wr) && count_value[15:0] != $past(count_value[15:0]) |->
		count_value[15:0] == $past(count_value[15:0]) + 16'h0001) else $error("counter moved by more than one");
	a_stop_holds: assert property (stop_cnt >= 3'h4 && !$past(wr) |-> $stable(count_value))
		else $error("counter moved while stopped");
endmodule : gtc_timer_properties

/* File: tb/gtc_timer_tb.sv */
// Self-checking bench for the general timer.
`timescale 1ns/1ps
module gtc_timer_tb import gtc_pkg::*;;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        pin = 1'b0;
	logic        gate = 1'b0;
	logic        idle = 1'b0;
	logic        rd_seen = 1'b0;
	logic [15:0] rdata;
	logic        counting;
	logic [31:0] count_value;
	logic [15:0] exp_q[$];
	int          n_mismatch = 0;
	int          checks = 0;
	int          dv[4] = '{1, 8, 64, 256};
	always #5 clk = ~clk;
	gtc_timer uut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .external_count_pin(pin),
		.gate_in(gate), .idle_mode(idle), .counting, .count_value);
	// One bus cycle; a read notes its expected answer for the monitor.
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic pulses(input int n);
		repeat (n) begin
			pin  <= 1'b1;
			gate <= 1'($urandom);
			repeat (2) @(posedge clk);
			pin <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : pulses
	task automatic print_verdict;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	always @(posedge clk) rd_seen <= rd;
	always @(negedge clk) begin
		if (rd_seen) begin
			checks++;
			if (rdata !== exp_q[0]) begin
				n_mismatch++;
				$display("MISMATCH rdata expected %h seen %h", exp_q[0], rdata);
			end
			void'(exp_q.pop_front());
		end
	end
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hFF9A));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(0, GTC_ADDR_CONTROL, 16'h0000);
		bus(1, GTC_ADDR_CONTROL, 16'hFFFF);
		bus(0, GTC_ADDR_CONTROL, GTC_CONTROL_MASK);
		bus(0, 4'h7, 16'h0000);
		// External edges with the gate option set and a random gate level.
		for (int p = 0; p < 4; p++) begin
			bus(1, GTC_ADDR_CONTROL, 16'h0000);
			bus(1, GTC_ADDR_COUNT_LO, 16'h0000);
			bus(1, GTC_ADDR_CONTROL, 16'h8042 | (16'(p) << 4));
			pulses(3 * dv[p] - 1);
			repeat (4) @(posedge clk);
			bus(0, GTC_ADDR_COUNT_LO, 16'h0002);
		end
		for (int m = 0; m < 2; m++) begin
			bus(1, GTC_ADDR_CONTROL, 16'h0000);
			bus(1, GTC_ADDR_COUNT_LO, 16'hFFFF);
			bus(1, GTC_ADDR_COUNT_HI, 16'h0005);
			bus(1, GTC_ADDR_CONTROL, 16'h8002 | (16'(m) << 3));
			pulses(1);
			repeat (4) @(posedge clk);
			bus(0, GTC_ADDR_COUNT_LO, 16'h0000);
			bus(0, GTC_ADDR_COUNT_HI, 16'h0005 + 16'(m));
		end
		// Internal clock for each prescale code with the gate ignored, then gated with the gate high.
		for (int q = 0; q < 5; q++) begin
			gate <= (q == 4) ? 1'b1 : 1'($urandom);
			bus(1, GTC_ADDR_CONTROL, 16'h0000);
			bus(1, GTC_ADDR_COUNT_LO, 16'h0000);
			bus(1, GTC_ADDR_CONTROL, (q < 4) ? (16'h8000 | (16'(q) << 4)) : 16'h8040);
			repeat (3 * dv[q % 4] - 1) @(posedge clk);
			bus(1, GTC_ADDR_CONTROL, 16'h0000);
			bus(0, GTC_ADDR_COUNT_LO, 16'h0003);
		end
		bus(1, GTC_ADDR_CONTROL, 16'h0000);
		bus(1, GTC_ADDR_COUNT_LO, 16'h0000);
		gate <= 1'b0;
		idle <= 1'b1;
		bus(1, GTC_ADDR_CONTROL, 16'hA040);
		repeat (20) @(posedge clk);
		bus(0, GTC_ADDR_STATUS, 16'h0000);
		idle <= 1'b0;
		repeat (20) @(posedge clk);
		bus(0, GTC_ADDR_COUNT_LO, 16'h0000);
		bus(0, GTC_ADDR_STATUS, 16'h0001);
		bus(1, GTC_ADDR_CONTROL, 16'h0000);
		repeat (10) @(posedge clk);
		print_verdict();
	end
endmodule : gtc_timer_tb
bind gtc_timer gtc_timer_properties chk (.clk, .rst, .addr, .wr, .rd, .rdata, .counting, .count_value);
